// file: audio_port_pkg.sv
package audio_port_pkg;

  // Register offsets on the control port
  localparam logic [7:0] FMT_LEN_OFS   = 8'h28;
  localparam logic [7:0] DATA_OFS_OFS  = 8'h29;
  localparam logic [7:0] ROUTING_OFS   = 8'h2a;
  localparam logic [7:0] PROGRAM_OFS   = 8'h2b;
  localparam logic [7:0] MISSING_OFS   = 8'h2c;

  // Field positions
  localparam int FRAME_FORMAT_LSB  = 4;
  localparam int SAMPLE_WIDTH_LSB  = 0;
  localparam int LEFT_PATH_LSB     = 4;
  localparam int RIGHT_PATH_LSB    = 0;
  localparam int PROGRAM_LSB       = 0;
  localparam int DETECT_STYLE_BIT  = 3;
  localparam int DETECT_PERIOD_LSB = 0;

  // Values after reset
  localparam logic [1:0] FRAME_FORMAT_RST  = 2'h0;
  localparam logic [1:0] SAMPLE_WIDTH_RST  = 2'h2;
  localparam logic [7:0] OFFSET_RST        = 8'h00;
  localparam logic [1:0] LEFT_PATH_RST     = 2'h1;
  localparam logic [1:0] RIGHT_PATH_RST    = 2'h1;
  localparam logic [4:0] PROGRAM_RST       = 5'h01;
  localparam logic       DETECT_STYLE_RST  = 1'b1;
  localparam logic [2:0] DETECT_PERIOD_RST = 3'h0;

  typedef enum logic [1:0] {
    FMT_I2S = 2'b00,
    FMT_DSP = 2'b01,
    FMT_RJ  = 2'b10,
    FMT_LJ  = 2'b11
  } frame_format_e;

  typedef enum logic [1:0] {
    PATH_MUTE  = 2'b00,
    PATH_OWN   = 2'b01,
    PATH_OTHER = 2'b10,
    PATH_RSVD  = 2'b11
  } path_e;

  // Timing of missing-clock detection
  localparam int CLK_HZ            = 10_000_000;
  localparam int MISSING_UNIT_S    = 1;
  localparam int SECOND_CYCLES     = MISSING_UNIT_S * CLK_HZ;
  localparam int TIMER_W           = 27;

  localparam int SAMPLE_W          = 32;
  localparam int FIFO_DEPTH        = 8;
  localparam int POS_W             = 11;

endpackage

// file: serial_audio_port_config.sv
`timescale 1ns/1ps

module sample_fifo #(
  parameter int W     = 64,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [W-1:0]  mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          full_q, full_d, vld_q, vld_d;
  logic          push, pop;

  always_comb
  begin
    push  = in_valid & ~full_q;
    pop   = vld_q & out_ready;
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    if (push)
    begin
      mem_d[wr_q] = in_data;
      wr_d        = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop)
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    cnt_d  = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    full_d = (cnt_d == (AW+1)'(DEPTH));
    vld_d  = (cnt_d != '0);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_q   <= '0;
      rd_q   <= '0;
      cnt_q  <= '0;
      full_q <= 1'b0;
      vld_q  <= 1'b0;
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else
    begin
      wr_q   <= wr_d;
      rd_q   <= rd_d;
      cnt_q  <= cnt_d;
      full_q <= full_d;
      vld_q  <= vld_d;
      mem_q  <= mem_d;
    end
  end

  assign in_ready  = ~full_q;
  assign out_valid = vld_q;
  assign out_data  = mem_q[rd_q];
endmodule

module serial_audio_port_config
  import audio_port_pkg::*;
#(
  parameter int SECOND_CYCLES_P = audio_port_pkg::SECOND_CYCLES
) (
  input  wire logic                             clk,
  input  wire logic                             rst,
  input  wire logic [7:0]                       reg_addr,
  input  wire logic [7:0]                       reg_wdata,
  input  wire logic                             reg_wr,
  output logic [7:0]                            reg_rdata,
  input  wire logic                             bit_clk,
  input  wire logic                             frame_clk,
  input  wire logic                             serial_data,
  input  wire logic                             ignore_missing_clocks,
  output logic                                  out_valid,
  input  wire logic                             out_ready,
  output logic [audio_port_pkg::SAMPLE_W-1:0]   out_left,
  output logic [audio_port_pkg::SAMPLE_W-1:0]   out_right,
  output logic [4:0]                            program_sel,
  output logic                                  clocks_missing,
  output logic                                  converter_powerdown,
  output logic                                  overflow_seen
);
  import audio_port_pkg::*;

  function automatic logic [POS_W-1:0] width_bits(input logic [1:0] code);
    case (code)
      2'h0:    width_bits = POS_W'(16);
      2'h1:    width_bits = POS_W'(20);
      2'h2:    width_bits = POS_W'(24);
      default: width_bits = POS_W'(32);
    endcase
  endfunction

  // ---------------- Register file, clk domain ----------------
  frame_format_e frame_format_sel_q, frame_format_sel_d;
  logic [1:0]    sample_width_sel_q, sample_width_sel_d;
  logic [7:0]    sample_bitclk_offset_q, sample_bitclk_offset_d;
  path_e         left_path_sel_q, left_path_sel_d, right_path_sel_q, right_path_sel_d;
  logic [4:0]    program_q, program_d;
  logic          missing_detect_style_q, missing_detect_style_d;
  logic [2:0]    missing_detect_period_q, missing_detect_period_d;
  logic [7:0]    rdata_q, rdata_d;

  always_comb
  begin
    frame_format_sel_d      = frame_format_sel_q;
    sample_width_sel_d      = sample_width_sel_q;
    sample_bitclk_offset_d  = sample_bitclk_offset_q;
    left_path_sel_d         = left_path_sel_q;
    right_path_sel_d        = right_path_sel_q;
    program_d               = program_q;
    missing_detect_style_d  = missing_detect_style_q;
    missing_detect_period_d = missing_detect_period_q;
    if (reg_wr)
    begin
      case (reg_addr)
        FMT_LEN_OFS:
        begin
          frame_format_sel_d = frame_format_e'(reg_wdata[FRAME_FORMAT_LSB +: 2]);
          sample_width_sel_d = reg_wdata[SAMPLE_WIDTH_LSB +: 2];
        end
        DATA_OFS_OFS: sample_bitclk_offset_d = reg_wdata;
        ROUTING_OFS:
        begin
          left_path_sel_d  = path_e'(reg_wdata[LEFT_PATH_LSB +: 2]);
          right_path_sel_d = path_e'(reg_wdata[RIGHT_PATH_LSB +: 2]);
        end
        PROGRAM_OFS: program_d = reg_wdata[PROGRAM_LSB +: 5];
        MISSING_OFS:
        begin
          missing_detect_style_d  = reg_wdata[DETECT_STYLE_BIT];
          missing_detect_period_d = reg_wdata[DETECT_PERIOD_LSB +: 3];
        end
        default: ;
      endcase
    end
    // Reserved bits read as zero, unmapped offsets read zero
    case (reg_addr)
      FMT_LEN_OFS:  rdata_d = {2'h0, frame_format_sel_q, 2'h0, sample_width_sel_q};
      DATA_OFS_OFS: rdata_d = sample_bitclk_offset_q;
      ROUTING_OFS:  rdata_d = {2'h0, left_path_sel_q, 2'h0, right_path_sel_q};
      PROGRAM_OFS:  rdata_d = {3'h0, program_q};
      MISSING_OFS:  rdata_d = {4'h0, missing_detect_style_q, missing_detect_period_q};
      default:      rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      frame_format_sel_q      <= frame_format_e'(FRAME_FORMAT_RST);
      sample_width_sel_q      <= SAMPLE_WIDTH_RST;
      sample_bitclk_offset_q  <= OFFSET_RST;
      left_path_sel_q         <= path_e'(LEFT_PATH_RST);
      right_path_sel_q        <= path_e'(RIGHT_PATH_RST);
      program_q               <= PROGRAM_RST;
      missing_detect_style_q  <= DETECT_STYLE_RST;
      missing_detect_period_q <= DETECT_PERIOD_RST;
      rdata_q                 <= 8'h00;
    end
    else
    begin
      frame_format_sel_q      <= frame_format_sel_d;
      sample_width_sel_q      <= sample_width_sel_d;
      sample_bitclk_offset_q  <= sample_bitclk_offset_d;
      left_path_sel_q         <= left_path_sel_d;
      right_path_sel_q        <= right_path_sel_d;
      program_q               <= program_d;
      missing_detect_style_q  <= missing_detect_style_d;
      missing_detect_period_q <= missing_detect_period_d;
      rdata_q                 <= rdata_d;
    end
  end

  assign reg_rdata   = rdata_q;
  assign program_sel = program_q;

  // ---------------- Missing-clock supervision, clk domain ----------------
  logic [1:0]         pin_raw;
  logic [1:0]         lo_done, hi_done;
  logic [TIMER_W-1:0] limit;
  logic               missing_q, missing_d, pdn_q, pdn_d;

  assign pin_raw = {frame_clk, bit_clk};
  assign limit   = TIMER_W'((missing_detect_period_q + 1) * SECOND_CYCLES_P);

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_watch
      logic               s1_q, s2_q;
      logic [TIMER_W-1:0] lo_q, lo_d, hi_q, hi_d;

      always_comb
      begin
        // Any high sample restarts the low timer
        lo_d = s2_q ? '0 : ((lo_q == limit) ? lo_q : lo_q + 1'b1);
        hi_d = ~s2_q ? '0 : ((hi_q == limit) ? hi_q : hi_q + 1'b1);
      end

      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          lo_q <= '0;
          hi_q <= '0;
        end
        else
        begin
          s1_q <= pin_raw[g];
          s2_q <= s1_q;
          lo_q <= lo_d;
          hi_q <= hi_d;
        end
      end

      assign lo_done[g] = (lo_q >= limit);
      assign hi_done[g] = (hi_q >= limit);
    end
  endgenerate

  always_comb
  begin
    if (missing_detect_style_q)
      missing_d = lo_done[0] | lo_done[1];
    else
      missing_d = hi_done[0] | hi_done[1] | (lo_done[0] & lo_done[1]);
    pdn_d = missing_d & ~ignore_missing_clocks;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      missing_q <= 1'b0;
      pdn_q     <= 1'b0;
    end
    else
    begin
      missing_q <= missing_d;
      pdn_q     <= pdn_d;
    end
  end

  assign clocks_missing      = missing_q;
  assign converter_powerdown = pdn_q;

  // ---------------- Receiver, bit clock domain ----------------
  logic [11:0]               cs1_q, cs2_q, cs3_q;
  logic                      lrst1_q, lrst2_q;
  frame_format_e             act_fmt_q, act_fmt_d;
  logic [1:0]                act_w_q, act_w_d;
  logic [7:0]                act_off_q, act_off_d;
  logic                      lr_q;
  logic [POS_W-1:0]          pos_q, pos_d, half_q, half_d;
  logic [SAMPLE_W-1:0]       lw_q, lw_d, rw_q, rw_d;
  logic [2*SAMPLE_W-1:0]     pair_q, pair_d;
  logic                      tog_q, tog_d;
  logic                      fstart, hstart, is_left, in_win, dsp;
  logic [POS_W-1:0]          w, base, ch_start, idx;

  always_comb
  begin
    dsp    = (act_fmt_q == FMT_DSP);
    // Left half opens on the falling edge for I2S, rising otherwise
    fstart = (frame_clk != lr_q) & (frame_clk == (act_fmt_q != FMT_I2S));
    hstart = dsp ? fstart : (frame_clk != lr_q);
    pos_d  = hstart ? '0 : ((pos_q == '1) ? pos_q : pos_q + 1'b1);
    half_d = hstart ? pos_q + 1'b1 : half_q;
    w      = width_bits(act_w_q);
    case (act_fmt_q)
      FMT_I2S: base = POS_W'(act_off_q) + 1'b1;
      FMT_RJ:  base = (half_q >= w) ? half_q - w + POS_W'(act_off_q) : POS_W'(act_off_q);
      default: base = POS_W'(act_off_q);
    endcase
    if (dsp)
      is_left = (pos_d < base + w);
    else if (act_fmt_q == FMT_I2S)
      is_left = ~frame_clk;
    else
      is_left = frame_clk;
    ch_start = (dsp & ~is_left) ? base + w : base;
    in_win   = (pos_d >= ch_start) & (pos_d < ch_start + w);
    idx      = pos_d - ch_start;
    lw_d     = lw_q;
    rw_d     = rw_q;
    if (in_win)
    begin
      // MSB first, left-aligned; a new sample clears stale low bits
      if (is_left)
      begin
        if (idx == '0)
          lw_d = '0;
        lw_d[5'(SAMPLE_W - 1 - int'(idx))] = serial_data;
      end
      else
      begin
        if (idx == '0)
          rw_d = '0;
        rw_d[5'(SAMPLE_W - 1 - int'(idx))] = serial_data;
      end
    end
    pair_d    = fstart ? {lw_q, rw_q} : pair_q;
    tog_d     = fstart ? ~tog_q : tog_q;
    act_fmt_d = act_fmt_q;
    act_w_d   = act_w_q;
    act_off_d = act_off_q;
    // Only a settled copy is taken, and only between frames
    if (fstart && cs2_q == cs3_q)
    begin
      act_fmt_d = frame_format_e'(cs3_q[11:10]);
      act_w_d   = cs3_q[9:8];
      act_off_d = cs3_q[7:0];
    end
  end

  always_ff @(posedge bit_clk)
  begin
    lrst1_q <= rst;
    lrst2_q <= lrst1_q;
    cs1_q   <= {frame_format_sel_q, sample_width_sel_q, sample_bitclk_offset_q};
    cs2_q   <= cs1_q;
    cs3_q   <= cs2_q;
    if (lrst2_q)
    begin
      act_fmt_q <= frame_format_e'(FRAME_FORMAT_RST);
      act_w_q   <= SAMPLE_WIDTH_RST;
      act_off_q <= OFFSET_RST;
      lr_q      <= 1'b0;
      pos_q     <= '0;
      half_q    <= '0;
      lw_q      <= '0;
      rw_q      <= '0;
      pair_q    <= '0;
      tog_q     <= 1'b0;
    end
    else
    begin
      act_fmt_q <= act_fmt_d;
      act_w_q   <= act_w_d;
      act_off_q <= act_off_d;
      lr_q      <= frame_clk;
      pos_q     <= pos_d;
      half_q    <= half_d;
      lw_q      <= lw_d;
      rw_q      <= rw_d;
      pair_q    <= pair_d;
      tog_q     <= tog_d;
    end
  end

  // ---------------- Crossing, routing and buffering, clk domain ----------------
  // Pair word holds for a whole frame, so a synchronised toggle is enough
  logic                  t1_q, t2_q, t3_q, push_q, push_d, ovf_q, ovf_d, fifo_ready;
  logic [2*SAMPLE_W-1:0] routed_q, routed_d, fifo_out;
  logic [SAMPLE_W-1:0]   src_l, src_r, dst_l, dst_r;

  always_comb
  begin
    src_l = pair_q[2*SAMPLE_W-1:SAMPLE_W];
    src_r = pair_q[SAMPLE_W-1:0];
    case (left_path_sel_q)
      PATH_OWN:   dst_l = src_l;
      PATH_OTHER: dst_l = src_r;
      default:    dst_l = '0;
    endcase
    case (right_path_sel_q)
      PATH_OWN:   dst_r = src_r;
      PATH_OTHER: dst_r = src_l;
      default:    dst_r = '0;
    endcase
    push_d   = t2_q ^ t3_q;
    routed_d = push_d ? {dst_l, dst_r} : routed_q;
    ovf_d    = ovf_q | (push_q & ~fifo_ready);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      t1_q     <= 1'b0;
      t2_q     <= 1'b0;
      t3_q     <= 1'b0;
      push_q   <= 1'b0;
      routed_q <= '0;
      ovf_q    <= 1'b0;
    end
    else
    begin
      t1_q     <= tog_q;
      t2_q     <= t1_q;
      t3_q     <= t2_q;
      push_q   <= push_d;
      routed_q <= routed_d;
      ovf_q    <= ovf_d;
    end
  end

  sample_fifo #(
    .W     (2 * SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push_q),
    .in_ready  (fifo_ready),
    .in_data   (routed_q),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_out)
  );

  assign out_left      = fifo_out[2*SAMPLE_W-1:SAMPLE_W];
  assign out_right     = fifo_out[SAMPLE_W-1:0];
  assign overflow_seen = ovf_q;
endmodule

// file: serial_audio_port_config_asserts.sv
`timescale 1ns/1ps

module serial_audio_port_config_asserts
  import audio_port_pkg::*;
#(
  parameter int SECOND_CYCLES_P = 50
) (
  input wire logic                                clk,
  input wire logic                                rst,
  input wire logic [7:0]                          reg_addr,
  input wire logic [7:0]                          reg_wdata,
  input wire logic                                reg_wr,
  input wire logic [7:0]                          reg_rdata,
  input wire logic                                bit_clk,
  input wire logic                                frame_clk,
  input wire logic                                serial_data,
  input wire logic                                ignore_missing_clocks,
  input wire logic                                out_valid,
  input wire logic                                out_ready,
  input wire logic [audio_port_pkg::SAMPLE_W-1:0] out_left,
  input wire logic [audio_port_pkg::SAMPLE_W-1:0] out_right,
  input wire logic [4:0]                          program_sel,
  input wire logic                                clocks_missing,
  input wire logic                                converter_powerdown,
  input wire logic                                overflow_seen
);
  import audio_port_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Slack for sync and flag stages
  localparam int LIM = SECOND_CYCLES_P - 8;
  logic bc_q;
  logic fc_q;
  int   sb_q;
  int   sb_d;
  int   sf_q;
  int   sf_d;
  always_comb
  begin
    sb_d = (rst || bit_clk != bc_q) ? 0 : sb_q + 1;
    sf_d = (rst || frame_clk != fc_q) ? 0 : sf_q + 1;
  end
  always_ff @(posedge clk)
  begin
    bc_q <= bit_clk;
    fc_q <= frame_clk;
    sb_q <= sb_d;
    sf_q <= sf_d;
  end
  pd_on_missing_a: assert property ((clocks_missing && !ignore_missing_clocks) [*2]
    |-> converter_powerdown) else $error("powerdown not raised");
  pd_ignored_a: assert property (!clocks_missing || $past(ignore_missing_clocks)
    |-> !converter_powerdown) else $error("powerdown without cause");
  missing_quiet_a: assert property ($rose(clocks_missing)
    |-> sb_q >= LIM || sf_q >= LIM) else $error("missing flagged too early");
  // Bit clock aliases against clk and may look still for six samples
  missing_clears_a: assert property ((sb_q < 8 && sf_q < 20) [*8]
    |-> !clocks_missing) else $error("missing while clocks run");
  unmapped_zero_a: assert property (!(reg_addr inside {[8'h28:8'h2c]})
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  fmt_rsvd_a: assert property (reg_addr == FMT_LEN_OFS
    |=> reg_rdata[7:6] == 2'h0 && reg_rdata[3:2] == 2'h0) else $error("reserved bits set");
  prog_read_a: assert property (reg_addr == PROGRAM_OFS && $stable(reg_addr)
    && !$past(reg_wr) && !$past(reg_wr, 2) && !$past(rst)
    |-> reg_rdata == {3'h0, program_sel}) else $error("program select differs");
  data_hold_a: assert property (out_valid && !out_ready
    |=> out_valid && $stable(out_left) && $stable(out_right)) else $error("pair not held");
  overflow_keep_a: assert property (overflow_seen |=> overflow_seen)
    else $error("overflow flag lost");
  pd_c: cover property ($rose(converter_powerdown));
  ovf_c: cover property ($rose(overflow_seen));
  pop_c: cover property (out_valid && out_ready);
endmodule

bind serial_audio_port_config serial_audio_port_config_asserts #(
  .SECOND_CYCLES_P(SECOND_CYCLES_P)
) chk_i (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rdata(reg_rdata), .bit_clk(bit_clk), .frame_clk(frame_clk),
  .serial_data(serial_data), .ignore_missing_clocks(ignore_missing_clocks),
  .out_valid(out_valid), .out_ready(out_ready), .out_left(out_left),
  .out_right(out_right), .program_sel(program_sel), .clocks_missing(clocks_missing),
  .converter_powerdown(converter_powerdown), .overflow_seen(overflow_seen)
);

// file: audio_source_model.sv
`timescale 1ns/1ps

module audio_source_model (
  input  wire logic        run,
  input  wire logic        hold_hi,
  input  wire logic [7:0]  ofs,
  input  wire logic [1:0]  fmt,
  input  wire logic [15:0] left,
  input  wire logic [15:0] right,
  output logic             bit_clk,
  output logic             frame_clk,
  output logic             serial_data
);
  logic [5:0]  k;
  logic [15:0] s;
  int          p;
  initial
  begin
    k = 6'h00;
    bit_clk = 1'b0;
    frame_clk = 1'b0;
    serial_data = 1'b0;
  end
  always
  begin
    if (!run)
    begin
      // Parked clocks; data keeps moving so a stale bit never looks valid
      bit_clk = hold_hi;
      frame_clk = hold_hi;
      serial_data = ~serial_data;
      k = 6'h00;
      #24;
    end
    else
    begin
      // Launch on falling edge, receiver samples on rising
      bit_clk = 1'b0;
      // I2S one bit late, RJ ends at half end, DSP right follows left
      frame_clk = k[5] ^ (fmt != 2'h0);
      p = int'(k[4:0]) - int'(ofs) - ((fmt == 2'h0) ? 1 : 0) - ((fmt == 2'h2) ? 16 : 0);
      s = (k[5] ^ (fmt == 2'h1 && p >= 16)) ? right : left;
      p = (fmt == 2'h1 && p >= 16) ? p - 16 : p;
      serial_data = (p >= 0 && p < 16) ? s[15-p] : ~serial_data;
      #24;
      bit_clk = 1'b1;
      #24;
      k = k + 6'h01;
    end
  end
endmodule

// file: test_serial_audio_port_config.sv
`timescale 1ns/1ps

module test_serial_audio_port_config;
  import audio_port_pkg::*;
  localparam logic [7:0] RA [6] = '{8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h30};
  localparam logic [7:0] RV [6] = '{8'h02, 8'h00, 8'h11, 8'h01, 8'h08, 8'h00};
  localparam logic [7:0] RM [6] = '{8'h33, 8'hff, 8'h33, 8'h1f, 8'h0f, 8'h00};
  localparam logic [7:0] WM [6] = '{8'h33, 8'hff, 8'h11, 8'h0f, 8'h0f, 8'hff};
  localparam logic [7:0] WO [6] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00};
  logic                clk;
  logic                rst;
  logic                reg_wr;
  logic                ign;
  logic                out_ready;
  logic                run;
  logic                hold_hi;
  logic                out_valid;
  logic                clocks_missing;
  logic                pdn;
  logic                ovf;
  logic                bclk;
  logic                fclk;
  logic                sdat;
  logic [7:0]          reg_addr;
  logic [7:0]          reg_wdata;
  logic [7:0]          reg_rdata;
  logic [7:0]          ofs;
  logic [7:0]          v;
  logic [7:0]          d;
  logic [1:0]          lc;
  logic [1:0]          rc;
  logic [1:0]          fm;
  logic [4:0]          psel;
  logic [15:0]         sl;
  logic [15:0]         sr;
  logic [SAMPLE_W-1:0] out_left;
  logic [SAMPLE_W-1:0] out_right;
  logic [SAMPLE_W-1:0] last_l;
  logic [SAMPLE_W-1:0] last_r;
  integer              seed;
  integer              error_cnt;
  integer              checks_done;
  integer              cyc;
  integer              pops;
  integer              n;

  serial_audio_port_config #(.SECOND_CYCLES_P(50)) DUT (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .bit_clk(bclk), .frame_clk(fclk), .serial_data(sdat),
    .ignore_missing_clocks(ign), .out_valid(out_valid), .out_ready(out_ready),
    .out_left(out_left), .out_right(out_right), .program_sel(psel),
    .clocks_missing(clocks_missing), .converter_powerdown(pdn), .overflow_seen(ovf)
  );
  audio_source_model src (
    .run(run), .hold_hi(hold_hi), .ofs(ofs), .fmt(fm), .left(sl), .right(sr),
    .bit_clk(bclk), .frame_clk(fclk), .serial_data(sdat)
  );

  function logic [31:0] route(input logic [1:0] c, input logic [15:0] own, oth);
    route = (c == 2'h1) ? {own, 16'h0} : (c == 2'h2) ? {oth, 16'h0} : 32'h0;
  endfunction
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Called at an edge: sees values settled before it
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done = checks_done + 1;
    if (g !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= x;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    chk(reg_rdata, e);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (out_valid === 1'b1 && out_ready === 1'b1)
    begin
      last_l <= out_left;
      last_r <= out_right;
      pops <= pops + 1;
    end
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      error_cnt = error_cnt + 1;
      stop_test;
    end
  end

  initial
  begin
    {rst, run, out_ready} = 3'b111;
    {reg_wr, ign, hold_hi, reg_addr, reg_wdata, ofs, sl, sr, fm} = '0;
    {error_cnt, checks_done, cyc, pops} = '0;
    seed = 32'hdca548f5;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      rd(RA[i], RV[i]);
      v = 8'($random(seed));
      d = (v & WM[i]) | WO[i] | ~RM[i];
      wr(RA[i], d);
      rd(RA[i], d & RM[i]);
    end
    for (int f = 0; f < 4; f++)
    begin
      wr(8'h28, 8'(f * 8'h11));
      rd(8'h28, 8'(f * 8'h11));
    end
    $display("test registers done");
    wr(8'h28, 8'h00);
    wr(8'h29, 8'h00);
    wr(8'h2c, 8'h08);
    for (int c = 0; c < 13; c++)
    begin
      // Pass 9 moves the sample deep into the half; passes 10-12 try DSP, RJ, LJ
      if (c == 9 || c == 10)
        wr(8'h29, (c == 9) ? 8'h0f : 8'h00);
      if (c >= 10)
        wr(8'h28, 8'((c - 9) * 16));
      fm <= (c >= 10) ? 2'(c - 9) : 2'h0;
      ofs <= (c == 9) ? 8'h0f : 8'h00;
      lc = (c >= 9) ? 2'h2 : 2'(c / 3);
      rc = (c >= 9) ? 2'h2 : 2'(c % 3);
      wr(8'h2a, {2'h0, lc, 2'h0, rc});
      sl <= 16'($random(seed));
      sr <= 16'($random(seed));
      repeat (160) @(posedge clk);
      chk(last_l, route(lc, sl, sr));
      chk(last_r, route(rc, sr, sl));
    end
    $display("test routing done");
    out_ready <= 1'b0;
    repeat (400) @(posedge clk);
    chk(ovf, 1'b1);
    run <= 1'b0;
    repeat (20) @(posedge clk);
    // Frame clock may have been low a half frame already
    chk(clocks_missing, 1'b0);
    n = pops;
    out_ready <= 1'b1;
    repeat (20) @(posedge clk);
    chk(pops - n, 8);
    repeat (25) @(posedge clk);
    chk(clocks_missing, 1'b1);
    chk(pdn, 1'b1);
    ign <= 1'b1;
    repeat (3) @(posedge clk);
    chk({clocks_missing, pdn}, 2'b10);
    ign <= 1'b0;
    $display("test buffer and missing done");
    run <= 1'b1;
    repeat (15) @(posedge clk);
    chk(clocks_missing, 1'b0);
    wr(8'h2c, 8'h09);
    run <= 1'b0;
    repeat (80) @(posedge clk);
    chk(clocks_missing, 1'b0);
    repeat (35) @(posedge clk);
    chk(clocks_missing, 1'b1);
    run <= 1'b1;
    wr(8'h2c, 8'h00);
    repeat (15) @(posedge clk);
    hold_hi <= 1'b1;
    run <= 1'b0;
    repeat (65) @(posedge clk);
    chk(clocks_missing, 1'b1);
    hold_hi <= 1'b0;
    repeat (20) @(posedge clk);
    chk(clocks_missing, 1'b0);
    repeat (45) @(posedge clk);
    chk(clocks_missing, 1'b1);
    $display("test period and style done");
    stop_test;
  end
endmodule
